// file: hdl/pi_ctrl_regs.svh
`ifndef PI_CTRL_REGS_SVH
`define PI_CTRL_REGS_SVH

// Register byte offsets on the Wishbone slave.
`define ADR_MODE      8'h00
`define ADR_INFUNC    8'h04
`define ADR_FB_LO     8'h08
`define ADR_FB_HI     8'h0C
`define ADR_KP        8'h10
`define ADR_KI        8'h14
`define ADR_RAMP      8'h18
`define ADR_ALM_LO    8'h1C
`define ADR_ALM_HI    8'h20
`define ADR_FILT      8'h24
`define ADR_SLP_THR   8'h28
`define ADR_SLP_DLY   8'h2C
`define ADR_SLP_BW    8'h30
`define ADR_CFG       8'h34
`define ADR_MAX_SPD   8'h38
`define ADR_STATUS    8'h40
`define ADR_VMON      8'h44
`define ADR_IMON      8'h48
`define ADR_FREQ      8'h4C
`define ADR_SETPT     8'h50

// Field positions.
`define INFUNC_A      7:0
`define INFUNC_B      15:8
`define INFUNC_C      23:16
`define CFG_SRC       1:0
`define CFG_OCF       3:2

// Reset values.
`define RST_MODE      3'h1
`define RST_FB_HI     16'h03E8
`define RST_KP        16'h0032
`define RST_RAMP      16'h00C8
`define RST_FILT      16'h0002
`define RST_SLP_DLY   16'h012C
`define RST_MAX_SPD   16'h0258

// Mode and function codes.
`define MODE_OFF      3'h1
`define MODE_DIR_I    3'h2
`define MODE_DIR_V    3'h3
`define MODE_REV_I    3'h4
`define MODE_REV_V    3'h5
`define KEYPAD_A      8'h0C
`define KEYPAD_B      8'h09
`define KEYPAD_C      8'h0A
`define SRC_KEYPAD    2'h0
`define SRC_VOLT      2'h1
`define SRC_CUR       2'h2
`define OCF_MIN       2'h0
`define OCF_MAX       2'h1
`define OCF_MINMAX    2'h2

// Scaling constants: 12-bit converter, 0 to 10 V or 0 to 20 mA full scale.
`define ADC_FULL      4095
`define ADC_4MA       819
`define ADC_2MA       12'h19A
`define FILT_FRAC     10
`define PV_MAX        9990
`define PCT_FULL      1000
`define INTEG_SCALE   1000
`define WAKE_MARGIN   16'h0014

// Timing: one control tick every 10 ms.
`define TICK_TIME_MS  10
`define CLK_RATE_MHZ  200
`define TICKS_PER_DS  10

`endif

// file: hdl/pi_ctrl_pkg.sv
`default_nettype none
package pi_ctrl_pkg;

  typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_SLEEP} run_state_t;

  typedef struct packed {
    logic              ack;
    logic [31:0]       rdat;
    logic [2:0]        mode;
    logic [23:0]       infunc;
    logic [3:0]        cfg;
    logic [15:0]       fb_lo;
    logic [15:0]       fb_hi;
    logic [15:0]       kp;
    logic [15:0]       ki;
    logic [15:0]       ramp;
    logic [15:0]       alm_lo;
    logic [15:0]       alm_hi;
    logic [15:0]       filt_n;
    logic [15:0]       thr;
    logic [15:0]       dly;
    logic [15:0]       bw;
    logic [15:0]       max_spd;
    logic [15:0]       key_sp;
    logic [15:0]       ramp_sp;
    logic [21:0]       tick_cnt;
    logic [31:0]       integ;
    logic [1:0][21:0]  filt;
    logic              run_prev;
    logic              up_prev;
    logic              dn_prev;
    run_state_t        state;
    logic [15:0]       slp_cnt;
    logic [15:0]       motor;
    logic [15:0]       disp;
    logic              closed;
    logic              lost;
    logic              low_alm;
    logic              high_alm;
    logic              oc_on;
  } ctrl_state_t;

endpackage
`default_nettype wire

// file: hdl/pi_setpoint_speed_control.sv
`include "pi_ctrl_regs.svh"
`default_nettype none

module pi_setpoint_speed_control
  import pi_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_TIME_MS * 1000 * `CLK_RATE_MHZ
)(
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Control terminals and front buttons; a closed select input reads low.
  input  wire logic        select_input_a_n_i,
  input  wire logic        select_input_b_n_i,
  input  wire logic        select_input_c_n_i,
  input  wire logic        key_up_i,
  input  wire logic        key_down_i,
  input  wire logic        run_i,
  input  wire logic [15:0] speed_ref_i,
  // Converted analog inputs.
  input  wire logic [11:0] analog_input_voltage_terminal_i,
  input  wire logic [11:0] analog_input_current_terminal_i,
  // Drive command and indications.
  output logic      [15:0] motor_speed_o,
  output logic      [15:0] display_value_o,
  output logic             closed_loop_o,
  output logic             sleep_indication_o,
  output logic             lost_feedback_indication_o,
  output logic             low_alarm_o,
  output logic             high_alarm_o,
  // Open-collector alarm pin.
  output logic             alarm_oc_o,
  output logic             alarm_oc_oe_n_o
);

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic            tick;
  logic            cur_fb;
  logic            reverse;
  logic            keypad_sel;
  logic            use_key;
  logic [1:0][11:0] filt_in;
  logic [1:0][21:0] filt_nxt;
  int              fbv;
  int              fbi;
  int              fb_pv;
  int              sp_tgt;
  int              span;
  int              err;
  int              pterm;
  int              iacc;
  int              cmd_pct;
  int              cmd_hz;
  int              step;
  int              rsp;

  // Linear map of a converter count onto the process range.
  function automatic int scale(input int raw, input int zero, input int lo, input int hi);
    scale = lo + ((hi - lo) * (raw - zero)) / (`ADC_FULL - zero);
  endfunction

  function automatic int clamp(input int v, input int lo, input int hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Byte-lane merge for partial Wishbone writes.
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++)
    begin
      lanes[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input filters and feedback scaling.

  // Each filter is a first-order lag; the setting counts 10 ms ticks, so 1 to 1000
  // gives 0.01 to 10 s. Fractional bits keep small errors from stalling the lag.
  assign filt_in[0] = analog_input_voltage_terminal_i;
  assign filt_in[1] = analog_input_current_terminal_i;
  for (genvar g = 0; g < 2; g++)
  begin : g_filt
    assign filt_nxt[g] = 22'(int'(s_q.filt[g]) + ((int'(filt_in[g]) << `FILT_FRAC)
                         - int'(s_q.filt[g])) / int'((s_q.filt_n == 16'h0000) ? 16'h0001
                         : s_q.filt_n));
  end

  // Both monitors are scaled whatever mode is active.
  assign fbv = scale(int'(s_q.filt[0][21:`FILT_FRAC]), 0, int'(s_q.fb_lo),
                     int'(s_q.fb_hi));
  assign fbi = scale(int'(s_q.filt[1][21:`FILT_FRAC]), `ADC_4MA, int'(s_q.fb_lo),
                     int'(s_q.fb_hi));
  assign cur_fb  = (s_q.mode == `MODE_DIR_I) || (s_q.mode == `MODE_REV_I);
  assign reverse = (s_q.mode == `MODE_REV_I) || (s_q.mode == `MODE_REV_V);
  assign fb_pv   = cur_fb ? fbi : fbv;

  ////////////////////////////////////////////////////////////////////////////
  // Setpoint selection and the PI law.

  assign keypad_sel = (!select_input_a_n_i && s_q.infunc[`INFUNC_A] == `KEYPAD_A)
                   || (!select_input_b_n_i && s_q.infunc[`INFUNC_B] == `KEYPAD_B)
                   || (!select_input_c_n_i && s_q.infunc[`INFUNC_C] == `KEYPAD_C);

  // An analog setpoint that is also the feedback signal would chase itself.
  assign use_key = (s_q.cfg[`CFG_SRC] == `SRC_KEYPAD)
                || (s_q.cfg[`CFG_SRC] == `SRC_VOLT && !cur_fb)
                || (s_q.cfg[`CFG_SRC] == `SRC_CUR && cur_fb);
  assign sp_tgt  = use_key ? int'(s_q.key_sp)
                 : ((s_q.cfg[`CFG_SRC] == `SRC_VOLT) ? fbv : fbi);

  // Error in tenths of a percent of the feedback span.
  assign span  = (s_q.fb_hi > s_q.fb_lo) ? int'(s_q.fb_hi - s_q.fb_lo)
               : ((s_q.fb_lo > s_q.fb_hi) ? int'(s_q.fb_lo - s_q.fb_hi) : 1);
  assign err   = ((reverse ? -1 : 1) * (int'(s_q.ramp_sp) - fb_pv) * `PCT_FULL)
               / span;
  assign pterm = (int'(s_q.kp) * err) / 10;
  // Per 10 ms tick the integral adds ki*err/1000 tenths of a percent.
  assign iacc  = clamp($signed(s_q.integ) + int'(s_q.ki) * err, 0,
                       `PCT_FULL * `INTEG_SCALE);
  assign cmd_pct = clamp(pterm + $signed(s_q.integ) / `INTEG_SCALE, 0, `PCT_FULL);
  assign cmd_hz  = s_q.closed ? (cmd_pct * int'(s_q.max_spd)) / `PCT_FULL
                 : int'(speed_ref_i);

  // Full-range ramp over the programmed time, at least one unit per tick.
  assign step = (s_q.ramp == 16'h0000) ? `PV_MAX
              : clamp(`PV_MAX / (int'(s_q.ramp) * `TICKS_PER_DS), 1, `PV_MAX);
  assign rsp  = (sp_tgt > int'(s_q.ramp_sp) + step) ? int'(s_q.ramp_sp) + step
              : ((sp_tgt < int'(s_q.ramp_sp) - step) ? int'(s_q.ramp_sp) - step
              : sp_tgt);

  assign tick = (s_q.tick_cnt == 22'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb
  begin
    s_d = s_q;
    s_d.tick_cnt = tick ? 22'h000000 : s_q.tick_cnt + 22'h000001;
    s_d.run_prev = run_i;
    s_d.up_prev  = key_up_i;
    s_d.dn_prev  = key_down_i;

    // Wishbone classic: ack one cycle after the strobe, dropped the cycle after.
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.rdat = 32'h00000000;
    if (wb_cyc_i && wb_stb_i && !s_q.ack)
    begin
      unique case (wb_adr_i)
        `ADR_MODE:    s_d.rdat = {29'h00000000, s_q.mode};
        `ADR_INFUNC:  s_d.rdat = {8'h00, s_q.infunc};
        `ADR_FB_LO:   s_d.rdat = {16'h0000, s_q.fb_lo};
        `ADR_FB_HI:   s_d.rdat = {16'h0000, s_q.fb_hi};
        `ADR_KP:      s_d.rdat = {16'h0000, s_q.kp};
        `ADR_KI:      s_d.rdat = {16'h0000, s_q.ki};
        `ADR_RAMP:    s_d.rdat = {16'h0000, s_q.ramp};
        `ADR_ALM_LO:  s_d.rdat = {16'h0000, s_q.alm_lo};
        `ADR_ALM_HI:  s_d.rdat = {16'h0000, s_q.alm_hi};
        `ADR_FILT:    s_d.rdat = {16'h0000, s_q.filt_n};
        `ADR_SLP_THR: s_d.rdat = {16'h0000, s_q.thr};
        `ADR_SLP_DLY: s_d.rdat = {16'h0000, s_q.dly};
        `ADR_SLP_BW:  s_d.rdat = {16'h0000, s_q.bw};
        `ADR_CFG:     s_d.rdat = {28'h0000000, s_q.cfg};
        `ADR_MAX_SPD: s_d.rdat = {16'h0000, s_q.max_spd};
        `ADR_STATUS:  s_d.rdat = {25'h0000000, s_q.state == ST_RUN, s_q.oc_on,
                                  s_q.high_alm, s_q.low_alm, s_q.lost,
                                  s_q.state == ST_SLEEP, s_q.closed};
        `ADR_VMON:    s_d.rdat = {16'h0000, 16'(fbv)};
        `ADR_IMON:    s_d.rdat = {16'h0000, 16'(fbi)};
        `ADR_FREQ:    s_d.rdat = {16'h0000, s_q.motor};
        `ADR_SETPT:   s_d.rdat = {16'h0000, s_q.ramp_sp};
        default:      s_d.rdat = 32'h00000000;
      endcase
      if (wb_we_i)
      begin
        unique case (wb_adr_i)
          `ADR_MODE:    s_d.mode    = 3'(lanes({29'h0, s_q.mode}, wb_dat_i, wb_sel_i));
          `ADR_INFUNC:  s_d.infunc  = 24'(lanes({8'h0, s_q.infunc}, wb_dat_i, wb_sel_i));
          `ADR_FB_LO:   s_d.fb_lo   = 16'(lanes({16'h0, s_q.fb_lo}, wb_dat_i, wb_sel_i));
          `ADR_FB_HI:   s_d.fb_hi   = 16'(lanes({16'h0, s_q.fb_hi}, wb_dat_i, wb_sel_i));
          `ADR_KP:      s_d.kp      = 16'(lanes({16'h0, s_q.kp}, wb_dat_i, wb_sel_i));
          `ADR_KI:      s_d.ki      = 16'(lanes({16'h0, s_q.ki}, wb_dat_i, wb_sel_i));
          `ADR_RAMP:    s_d.ramp    = 16'(lanes({16'h0, s_q.ramp}, wb_dat_i, wb_sel_i));
          `ADR_ALM_LO:  s_d.alm_lo  = 16'(lanes({16'h0, s_q.alm_lo}, wb_dat_i, wb_sel_i));
          `ADR_ALM_HI:  s_d.alm_hi  = 16'(lanes({16'h0, s_q.alm_hi}, wb_dat_i, wb_sel_i));
          `ADR_FILT:    s_d.filt_n  = 16'(lanes({16'h0, s_q.filt_n}, wb_dat_i, wb_sel_i));
          `ADR_SLP_THR: s_d.thr     = 16'(lanes({16'h0, s_q.thr}, wb_dat_i, wb_sel_i));
          `ADR_SLP_DLY: s_d.dly     = 16'(lanes({16'h0, s_q.dly}, wb_dat_i, wb_sel_i));
          `ADR_SLP_BW:  s_d.bw      = 16'(lanes({16'h0, s_q.bw}, wb_dat_i, wb_sel_i));
          `ADR_CFG:     s_d.cfg     = 4'(lanes({28'h0, s_q.cfg}, wb_dat_i, wb_sel_i));
          `ADR_MAX_SPD: s_d.max_spd = 16'(lanes({16'h0, s_q.max_spd}, wb_dat_i, wb_sel_i));
          default:      s_d.mode    = s_q.mode;
        endcase
      end
    end

    // Front buttons step the keypad setpoint by one unit per press.
    if (key_up_i && !s_q.up_prev && s_q.key_sp < 16'(`PV_MAX))
      s_d.key_sp = s_q.key_sp + 16'h0001;
    else if (key_down_i && !s_q.dn_prev && s_q.key_sp != 16'h0000)
      s_d.key_sp = s_q.key_sp - 16'h0001;

    // Closed loop needs an enabled mode and a closed keypad-coded select input.
    s_d.closed = (s_q.mode >= `MODE_DIR_I) && (s_q.mode <= `MODE_REV_V)
              && keypad_sel;

    if (tick)
    begin
      for (int c = 0; c < 2; c++)
        s_d.filt[c] = filt_nxt[c];
      s_d.ramp_sp = 16'(rsp);
      s_d.integ   = s_q.closed ? 32'(iacc) : 32'h00000000;
    end
    if (s_q.ramp == 16'h0000)
      s_d.ramp_sp = 16'(sp_tgt);

    // Alarms compare the scaled feedback with the alarm levels.
    s_d.low_alm  = fb_pv < int'(s_q.alm_lo);
    s_d.high_alm = fb_pv > int'(s_q.alm_hi);
    unique case (s_q.cfg[`CFG_OCF])
      `OCF_MIN:    s_d.oc_on = !(fb_pv < int'(s_q.alm_lo));
      `OCF_MAX:    s_d.oc_on = !(fb_pv > int'(s_q.alm_hi));
      `OCF_MINMAX: s_d.oc_on = !(fb_pv < int'(s_q.alm_lo)) && !(fb_pv > int'(s_q.alm_hi));
      default:     s_d.oc_on = 1'b0;
    endcase
    s_d.lost = cur_fb && (analog_input_current_terminal_i < `ADC_2MA);

    // Sleep and run sequencing.
    unique case (s_q.state)
      ST_STOP:
      begin
        s_d.slp_cnt = 16'(int'(s_q.dly) * `TICKS_PER_DS);
        if (run_i && !s_q.run_prev)
          s_d.state = (cmd_hz < int'(s_q.thr)) ? ST_SLEEP : ST_RUN;
      end
      ST_RUN:
      begin
        if (!run_i)
          s_d.state = ST_STOP;
        else if (cmd_hz >= int'(s_q.thr))
          s_d.slp_cnt = 16'(int'(s_q.dly) * `TICKS_PER_DS);
        else if (s_q.slp_cnt == 16'h0000)
          s_d.state = ST_SLEEP;
        else if (tick)
          s_d.slp_cnt = s_q.slp_cnt - 16'h0001;
      end
      ST_SLEEP:
      begin
        s_d.slp_cnt = 16'(int'(s_q.dly) * `TICKS_PER_DS);
        if (!run_i)
          s_d.state = ST_STOP;
        else if (cmd_hz >= int'(s_q.thr) + int'(`WAKE_MARGIN))
          s_d.state = ST_RUN;
        else if (s_q.bw != 16'h0000 && s_q.closed
                 && (reverse ? (fb_pv > int'(s_q.ramp_sp) + int'(s_q.bw))
                             : (fb_pv < int'(s_q.ramp_sp) - int'(s_q.bw))))
          s_d.state = ST_RUN;
      end
      default: s_d.state = ST_STOP;
    endcase

    // The motor is held at zero unless running; the outer drive ramps it.
    s_d.motor = (s_q.state == ST_RUN) ? 16'(cmd_hz) : 16'h0000;
    s_d.disp  = s_q.closed ? 16'(fb_pv) : s_q.motor;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_q         <= '0;
      s_q.mode    <= `RST_MODE;
      s_q.fb_hi   <= `RST_FB_HI;
      s_q.kp      <= `RST_KP;
      s_q.ramp    <= `RST_RAMP;
      s_q.filt_n  <= `RST_FILT;
      s_q.dly     <= `RST_SLP_DLY;
      s_q.max_spd <= `RST_MAX_SPD;
      s_q.state   <= ST_STOP;
    end
    else
      s_q <= s_d;
  end

  // Outputs come straight from the state register, except alarm_oc_o, which is tied low.
  assign wb_ack_o                   = s_q.ack;
  assign wb_dat_o                   = s_q.rdat;
  assign motor_speed_o              = s_q.motor;
  assign display_value_o            = s_q.disp;
  assign closed_loop_o              = s_q.closed;
  assign sleep_indication_o         = s_q.state == ST_SLEEP;
  assign lost_feedback_indication_o = s_q.lost;
  assign low_alarm_o                = s_q.low_alm;
  assign high_alarm_o               = s_q.high_alm;
  assign alarm_oc_o                 = 1'b0;
  assign alarm_oc_oe_n_o            = !s_q.oc_on;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_wb_ack_pulse: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_lost_flag: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (cur_fb && analog_input_current_terminal_i < `ADC_2MA) |=> lost_feedback_indication_o)
    else $error("lost feedback not flagged");
  a_low_alarm: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (fb_pv < int'(s_q.alm_lo)) |=> low_alarm_o) else $error("low alarm missed");
  a_high_alarm: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (fb_pv > int'(s_q.alm_hi)) |=> high_alarm_o) else $error("high alarm missed");
  a_oc_min: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s_q.cfg[`CFG_OCF] == `OCF_MIN && fb_pv >= int'(s_q.alm_lo)) |=> !alarm_oc_oe_n_o)
    else $error("open collector not energized");
  a_sleep_stop: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    sleep_indication_o[*2] |-> motor_speed_o == 16'h0000) else $error("motor runs in sleep");
  a_start_sleep: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s_q.state == ST_STOP && run_i && !s_q.run_prev && cmd_hz < int'(s_q.thr))
    |=> sleep_indication_o) else $error("start below threshold did not sleep");
  a_open_loop: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (!s_q.closed && s_q.state == ST_RUN && $stable(speed_ref_i) && !$changed(s_q.state))
    |=> motor_speed_o == $past(speed_ref_i)) else $error("open loop not followed");
  a_wake_margin: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s_q.state == ST_SLEEP && run_i && cmd_hz >= int'(s_q.thr) + int'(`WAKE_MARGIN))
    |=> !sleep_indication_o) else $error("no wake above margin");

  c_sleep_entry: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    s_q.state == ST_RUN ##1 s_q.state == ST_SLEEP);
  c_wake: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    s_q.state == ST_SLEEP ##1 s_q.state == ST_RUN);
  c_closed: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    closed_loop_o && motor_speed_o != 16'h0000);

endmodule // pi_setpoint_speed_control
`default_nettype wire

// file: testbench/transducer_model.sv
`default_nettype none
module transducer_model
(
  // Process levels set by the bench.
  input  wire logic [9:0]  volt_cv_i,
  input  wire logic [7:0]  amp_dma_i,
  // Converter codes seen by the drive.
  output logic      [11:0] volt_code_o,
  output logic      [11:0] amp_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Straight-line transfer; the bench must keep levels within full scale.
  assign volt_code_o = 12'((32'(volt_cv_i) * 4095) / 1000);
  assign amp_code_o  = 12'((32'(amp_dma_i) * 4095) / 200);
endmodule // transducer_model
`default_nettype wire

// file: testbench/tb_pi_setpoint_speed_control.sv
`default_nettype none
module tb_pi_setpoint_speed_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, cyc, stb, we, run, up, dn, lo, hi, oen, cl, sleep_indication, lost, ack, ocv;
  logic [2:0] sel_n;
  logic [7:0] adr, ama;
  logic [9:0] vcv;
  logic [11:0] vc, ac;
  logic [15:0] sref, mot, disp;
  logic [31:0] wd, rd, q;
  int mismatches, checks_done;
  // Short control tick keeps filter and sleep timing within a brief run.
  pi_setpoint_speed_control #(.TICK_CYCLES(20)) dut (.core_clk_i(clk), .nrst_i(nrst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .select_input_a_n_i(sel_n[0]),
    .select_input_b_n_i(sel_n[1]), .select_input_c_n_i(sel_n[2]), .key_up_i(up),
    .key_down_i(dn), .run_i(run), .speed_ref_i(sref), .analog_input_voltage_terminal_i(vc),
    .analog_input_current_terminal_i(ac), .motor_speed_o(mot), .display_value_o(disp),
    .closed_loop_o(cl), .sleep_indication_o(sleep_indication), .lost_feedback_indication_o(lost),
    .low_alarm_o(lo), .high_alarm_o(hi), .alarm_oc_o(ocv), .alarm_oc_oe_n_o(oen));
  transducer_model plant (.volt_cv_i(vcv), .amp_dma_i(ama), .volt_code_o(vc), .amp_code_o(ac));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // One classic cycle; request held until ack is sampled, then released.
  // No cycle count is assumed here: a slave that never answers is left to the watchdog.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic summarize();
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    summarize();
  end
  // Reset defaults, open loop, alarms, closed-loop entry, lost signal, sleep.
  initial
  begin
    logic [7:0] ra [7] = '{8'h00, 8'h0C, 8'h10, 8'h18, 8'h24, 8'h2C, 8'h38};
    logic [15:0] rv [7] = '{16'h1, 16'h3E8, 16'h32, 16'hC8, 16'h2, 16'h12C, 16'h258};
    logic [7:0] code [3] = '{8'h0C, 8'h09, 8'h0A};
    {nrst, cyc, stb, we, run, up, dn, adr, wd, ama, vcv} = '0;
    sel_n = 3'h7; sref = 16'h0100; ama = 8'd40;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    foreach (ra[i]) begin bus(0, ra[i], 0); chk("reset value", 32'(rv[i]), q); end
    bus(0, 8'h3C, 0); chk("unmapped", 0, q);
    run <= 1'b1;
    repeat (10) @(posedge clk);
    chk("open loop speed", 32'h0100, 32'(mot));
    bus(1, 8'h24, 1); bus(1, 8'h1C, 32'h64); bus(1, 8'h20, 32'h1F4); bus(1, 8'h00, 3);
    repeat (1000) @(posedge clk);
    chk("low alarm", 1, 32'(lo)); chk("oc off", 1, 32'(oen));
    vcv <= 10'd1000;
    repeat (1000) @(posedge clk);
    chk("high alarm", 1, 32'(hi)); chk("oc on", 0, 32'(oen));
    chk("oc level", 0, 32'(ocv));
    bus(0, 8'h44, 0);
    chk("voltage monitor", 32'h3E8, q);
    foreach (code[i])
    begin
      bus(1, 8'h04, 32'(code[i]) << (8 * i));
      sel_n[i] <= 1'b0;
      repeat (3) @(posedge clk);
      chk("closed loop", 1, 32'(cl));
      sel_n[i] <= 1'b1;
    end
    // Reverse acting with swapped scale ends: gain 0.1 on a 100 % error gives 10 % speed.
    bus(1, 8'h10, 1);
    bus(1, 8'h00, 5);
    bus(1, 8'h08, 32'h3E8);
    bus(1, 8'h0C, 0);
    vcv <= 10'd0;
    sel_n[2] <= 1'b0;
    repeat (60) @(posedge clk);
    chk("reverse speed", 32'h3C, 32'(mot));
    chk("display", 32'h3E8, 32'(disp));
    bus(0, 8'h4C, 0);
    chk("frequency", 32'h3C, q);
    sel_n[2] <= 1'b1;
    bus(1, 8'h00, 2); ama <= 8'd19;
    repeat (1000) @(posedge clk);
    chk("lost feedback", 1, 32'(lost));
    bus(1, 8'h00, 1); run <= 1'b0; sref <= 16'h10; bus(1, 8'h28, 32'h64);
    run <= 1'b1;
    repeat (3) @(posedge clk);
    chk("sleep on start", 1, 32'(sleep_indication)); chk("stopped", 0, 32'(mot));
    sref <= 16'h77;
    repeat (5) @(posedge clk);
    chk("still asleep", 1, 32'(sleep_indication));
    sref <= 16'h78;
    repeat (5) @(posedge clk);
    chk("awake", 0, 32'(sleep_indication));
    bus(1, 8'h2C, 1); sref <= 16'h10;
    repeat (100) @(posedge clk);
    chk("delay running", 0, 32'(sleep_indication));
    repeat (300) @(posedge clk);
    chk("delay expired", 1, 32'(sleep_indication));
    // Zero ramp time lets the keypad setpoint reach the controller at once.
    bus(1, 8'h18, 0);
    repeat (3)
    begin
      up <= 1'b1;
      @(posedge clk);
      up <= 1'b0;
      @(posedge clk);
    end
    dn <= 1'b1;
    @(posedge clk);
    dn <= 1'b0;
    bus(0, 8'h50, 0);
    chk("keypad setpoint", 32'h2, q);
    summarize();
  end
endmodule // tb_pi_setpoint_speed_control
`default_nettype wire
